// *** core/cond_regs_pkg.sv ***
// Package of register offsets, fields, reset values and carrier types for the conditioner register bank
// Notes on behaviour
// - A 5-bit pointer, values 0 through 8, selects nine registers numbered 0 to 8.
// - Registers 0 and 8 are read-only; registers 1 to 7 are readable and writable.
// - Register 8 reports the present fault monitor comparator outputs.
// - In internal mode the result is a 12-bit magnitude plus sign, two's complement, right-justified and sign-extended.
// - One internal-mode count is one sixteenth of a degree, negatives as two's complement of the count.
// - In external mode the result is a 15-bit magnitude plus sign, two's complement, right-justified.
// - Internal temperature mode is selected when bit 9 of register 6 is one.
// - The external result is a signed fraction of full scale, 7FFF just below plus full scale, 8000 at minus full scale.
// - Register 6 holds converter speed, reference, mode, external amplifier setup and current source enable.
// - Register 7 holds the converter delay and the one-wire output enable timing.
// - Register 4 holds coarse offset, front-end gain, output gain and one-wire disable.
// - Register 5 holds over/under-scale limits, polarities, enable and fault comparator select.
// - Registers 1 and 2 hold fine offset and fine gain; register 3 holds reference, excitation and linearization.
package cond_regs_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] ADDR_TEMP_RESULT = 5'h00;
    localparam logic [4:0] ADDR_FINE_OFFSET = 5'h01;
    localparam logic [4:0] ADDR_FINE_GAIN = 5'h02;
    localparam logic [4:0] ADDR_REF_LIN = 5'h03;
    localparam logic [4:0] ADDR_COARSE_GAIN = 5'h04;
    localparam logic [4:0] ADDR_SCALE_LIMIT = 5'h05;
    localparam logic [4:0] ADDR_TEMP_CTRL = 5'h06;
    localparam logic [4:0] ADDR_OE_COUNT = 5'h07;
    localparam logic [4:0] ADDR_ALARM = 5'h08;
    localparam int TEMP_MODE_BIT = 9;
    localparam int INT_MAG_W = 12;
    localparam int EXT_MAG_W = 15;
    // Power-on values of all nine registers, the read-only registers 0 and 8 included
    localparam logic [15:0] RST_TEMP_RESULT = 16'h0000;
    localparam logic [15:0] RST_FINE_OFFSET = 16'h4000;
    localparam logic [15:0] RST_FINE_GAIN = 16'h4000;
    localparam logic [15:0] RST_REF_LIN = 16'h0000;
    localparam logic [15:0] RST_COARSE_GAIN = 16'h0000;
    localparam logic [15:0] RST_SCALE_LIMIT = 16'h0000;
    localparam logic [15:0] RST_TEMP_CTRL = 16'h0000;
    localparam logic [15:0] RST_OE_COUNT = 16'h0000;
    localparam logic [15:0] RST_ALARM = 16'h0000;
    localparam int NUM_RW = 7;

    // Bus request carrier
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    // Converter sample carrier
    typedef struct packed {
        logic valid;
        logic internalMode;
        logic [15:0] raw;
    } conv_sample_type;
endpackage

// *** core/setting_store.sv ***
// Small memory of the seven writable setting words with registered read data
`timescale 1ns/1ns
module setting_store
    import cond_regs_pkg::*;
#(
    parameter int WORDS = 7
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write side
    input wire logic wrEn,
    input wire logic [2:0] wrIdx,
    input wire logic [15:0] wrData,
    // Read side
    input wire logic [2:0] rdIdx,
    output logic [15:0] rdData,
    // Whole contents for the analog controls
    output logic [WORDS*16-1:0] flat
);
    logic [15:0] mem [WORDS];
    logic [15:0] next_mem [WORDS];
    logic [15:0] next_rdData;

    // Reset image chosen per word so that each register powers up to its own value
    function automatic logic [15:0] reset_word(input int idx);
        unique case (idx)
            0: reset_word = RST_FINE_OFFSET;
            1: reset_word = RST_FINE_GAIN;
            2: reset_word = RST_REF_LIN;
            3: reset_word = RST_COARSE_GAIN;
            4: reset_word = RST_SCALE_LIMIT;
            5: reset_word = RST_TEMP_CTRL;
            default: reset_word = RST_OE_COUNT;
        endcase
    endfunction

    // Next contents and read word
    always_comb
    begin
        for (int i = 0; i < WORDS; i++)
        begin
            next_mem[i] = (wrEn && wrIdx == 3'(i)) ? wrData : mem[i];
        end
        next_rdData = (rdIdx < 3'(WORDS)) ? mem[rdIdx] : 16'h0000;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                mem[i] <= reset_word(i);
            end
            rdData <= 16'h0000;
        end
        else
        begin
            mem <= next_mem;
            rdData <= next_rdData;
        end
    end

    // Flattened view, word 0 in the low bits
    genvar g;
    generate
        for (g = 0; g < WORDS; g++)
        begin : gFlat
            assign flat[g*16 +: 16] = mem[g];
        end
    endgenerate
endmodule

// *** core/sensor_conditioner_register_map.sv ***
// Register bank of the sensor conditioner: pointer decode, settings, temperature result and alarm status
`timescale 1ns/1ns
module sensor_conditioner_register_map
    import cond_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [4:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [15:0] rdData,
    // Temperature converter result, same clock domain
    input wire logic convValid,
    input wire logic [15:0] convRaw,
    // Fault comparator outputs from the analog side
    input wire logic [15:0] faultComparators,
    // Settings to the analog blocks
    output logic [15:0] fineOffset,
    output logic [15:0] fineGain,
    output logic [15:0] refAndLin,
    output logic [15:0] coarseAndGain,
    output logic [15:0] scaleLimit,
    output logic [15:0] tempCtrl,
    output logic [15:0] oeCount,
    output logic internalTempMode
);
    logic [15:0] tempResult;
    logic [15:0] next_tempResult;
    logic [15:0] alarmSync1;
    logic [15:0] alarmSync2;
    logic [15:0] alarm;
    logic [15:0] next_alarm;
    logic [3:0] rwSel;
    logic storeWr;
    logic [2:0] storeWrIdx;
    logic [2:0] storeRdIdx;
    logic [NUM_RW*16-1:0] flat;
    logic [15:0] next_rdData;
    logic [15:0] next_fineOffset;
    logic [15:0] next_fineGain;
    logic [15:0] next_refAndLin;
    logic [15:0] next_coarseAndGain;
    logic [15:0] next_scaleLimit;
    logic [15:0] next_tempCtrl;
    logic [15:0] next_oeCount;
    logic next_internalTempMode;
    bus_req_type req;
    conv_sample_type sample;

    // Pointer to writable-word index; returns 1 in valid when the pointer names registers 1 to 7
    function automatic logic [3:0] rw_index(input logic [4:0] a);
        if (a >= ADDR_FINE_OFFSET && a <= ADDR_OE_COUNT)
            rw_index = {1'b1, 3'(a - ADDR_FINE_OFFSET)};
        else
            rw_index = 4'h0;
    endfunction

    // Sign-extend a result to the full word according to mode
    function automatic logic [15:0] format_result(input conv_sample_type s);
        if (s.internalMode)
            format_result = {{(16-INT_MAG_W-1){s.raw[INT_MAG_W]}}, s.raw[INT_MAG_W:0]};
        else
            format_result = {s.raw[EXT_MAG_W], s.raw[EXT_MAG_W-1:0]};
    endfunction

    assign req = '{addr: addr, wdata: wrData, wr: wrStrobe, rd: rdStrobe};
    assign sample = '{valid: convValid, internalMode: internalTempMode, raw: convRaw};

    // Pointer decode held in a net, since a call result cannot be bit-selected
    assign rwSel = rw_index(req.addr);
    // Only registers 1 to 7 accept writes; 0, 8 and unused pointers drop them
    assign storeWr = req.wr && rwSel[3];
    assign storeWrIdx = rwSel[2:0];
    assign storeRdIdx = rwSel[2:0];

    setting_store #(
        .WORDS(NUM_RW)
    ) uStore (
        .clk(clk),
        .rst(rst),
        .wrEn(storeWr),
        .wrIdx(storeWrIdx),
        .wrData(req.wdata),
        .rdIdx(storeRdIdx),
        .rdData(),
        .flat(flat)
    );

    // Comparator outputs come from analog logic, so they are synchronised first
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            alarmSync1 <= RST_ALARM;
            alarmSync2 <= RST_ALARM;
        end
        else
        begin
            alarmSync1 <= faultComparators;
            alarmSync2 <= alarmSync1;
        end
    end

    // Result and alarm values; the alarm is a live view, not a latched one
    always_comb
    begin
        next_tempResult = tempResult;
        if (sample.valid)
        begin
            // Internal: 12-bit plus sign at 1/16 degree per count, sign-extended
            // External: 15-bit plus sign fraction of full scale, 7FFF to 8000
            next_tempResult = format_result(sample);
        end
        next_alarm = alarmSync2;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tempResult <= RST_TEMP_RESULT;
            alarm <= RST_ALARM;
        end
        else
        begin
            tempResult <= next_tempResult;
            alarm <= next_alarm;
        end
    end

    // Read word for the output flop; the store's own registered read would land a
    // cycle late for the one-cycle port, so settings come from its flat view
    always_comb
    begin
        next_rdData = 16'h0000;
        if (req.rd)
        begin
            if (req.addr == ADDR_TEMP_RESULT)
                next_rdData = tempResult;
            else if (req.addr == ADDR_ALARM)
                next_rdData = alarm;
            else if (rwSel[3])
                next_rdData = flat[16*storeRdIdx +: 16];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdData <= 16'h0000;
        else
            rdData <= next_rdData;
    end

    // Settings to the analog side, registered so outputs come from flops
    always_comb
    begin
        next_fineOffset = flat[0*16 +: 16];
        next_fineGain = flat[1*16 +: 16];
        next_refAndLin = flat[2*16 +: 16];
        next_coarseAndGain = flat[3*16 +: 16];
        next_scaleLimit = flat[4*16 +: 16];
        next_tempCtrl = flat[5*16 +: 16];
        next_oeCount = flat[6*16 +: 16];
        next_internalTempMode = flat[5*16 + TEMP_MODE_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fineOffset <= RST_FINE_OFFSET;
            fineGain <= RST_FINE_GAIN;
            refAndLin <= RST_REF_LIN;
            coarseAndGain <= RST_COARSE_GAIN;
            scaleLimit <= RST_SCALE_LIMIT;
            tempCtrl <= RST_TEMP_CTRL;
            oeCount <= RST_OE_COUNT;
            internalTempMode <= RST_TEMP_CTRL[TEMP_MODE_BIT];
        end
        else
        begin
            fineOffset <= next_fineOffset;
            fineGain <= next_fineGain;
            refAndLin <= next_refAndLin;
            coarseAndGain <= next_coarseAndGain;
            scaleLimit <= next_scaleLimit;
            tempCtrl <= next_tempCtrl;
            oeCount <= next_oeCount;
            internalTempMode <= next_internalTempMode;
        end
    end
endmodule

// *** bench/cond_regs_chk.sv ***
// Port checks of the conditioner register bank
`timescale 1ns/1ns
module cond_regs_chk
    import cond_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [4:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [15:0] rdData,
    // Settings
    input wire logic [15:0] fineOffset,
    input wire logic [15:0] fineGain,
    input wire logic [15:0] coarseAndGain,
    input wire logic [15:0] scaleLimit,
    input wire logic [15:0] tempCtrl,
    input wire logic [15:0] oeCount,
    input wire logic internalTempMode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Strobes aimed at one pointer value
    sequence regWrite(logic [4:0] a);
        wrStrobe && addr == a;
    endsequence
    sequence regRead(logic [4:0] a);
        rdStrobe && addr == a;
    endsequence
    // Read data stand one cycle only, so a stale word cannot be taken twice
    read_idle_zero_a: assert property (!$past(rdStrobe) |-> rdData == 16'h0000)
        else $error("read data not zero outside the read cycle");
    offset_write_a: assert property (regWrite(ADDR_FINE_OFFSET) |-> ##2 fineOffset == $past(wrData, 2))
        else $error("fine offset not updated after write");
    ctrl_write_a: assert property (regWrite(ADDR_TEMP_CTRL) |-> ##2 tempCtrl == $past(wrData, 2))
        else $error("converter control not updated after write");
    mode_write_a: assert property (regWrite(ADDR_TEMP_CTRL) |-> ##2 internalTempMode == $past(wrData[9], 2))
        else $error("mode output does not follow control bit");
    limit_hold_a: assert property (!$past(wrStrobe, 2) |-> $stable(scaleLimit))
        else $error("limit settings changed without a write");
    gain_read_a: assert property (regRead(ADDR_FINE_GAIN) |=> rdData == fineGain)
        else $error("fine gain read differs from setting");
    count_read_a: assert property (regRead(ADDR_OE_COUNT) |=> rdData == oeCount)
        else $error("delay setting read differs");
    coarse_read_a: assert property (regRead(ADDR_COARSE_GAIN) |=> rdData == coarseAndGain)
        else $error("coarse setting read differs");
    unused_read_a: assert property (rdStrobe && addr > ADDR_ALARM |=> rdData == 16'h0000)
        else $error("unused pointer read not zero");
endmodule

bind sensor_conditioner_register_map cond_regs_chk u_chk (.clk(clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .fineOffset(fineOffset), .fineGain(fineGain), .coarseAndGain(coarseAndGain),
    .scaleLimit(scaleLimit), .tempCtrl(tempCtrl), .oeCount(oeCount), .internalTempMode(internalTempMode));

// *** bench/host_model.sv ***
// Host model that drives the register port
`timescale 1ns/1ns
module host_model
    import cond_regs_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [4:0] addr,
    output logic [15:0] wrData,
    output logic wrStrobe,
    output logic rdStrobe,
    input wire logic [15:0] rdData
);
    // Port idle at time zero
    initial
    begin
        addr = 5'h00;
        wrData = 16'h0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    // Write; data inverted afterwards so a stale word never looks valid
    task automatic put(input logic [4:0] a, input logic [15:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        wrData <= ~d;
    endtask

    // Read; data taken at the edge that closes the one cycle they stand
    task automatic get(input logic [4:0] a, output logic [15:0] d);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        @(posedge clk);
        d = rdData;
    endtask
endmodule

// *** bench/sensor_conditioner_register_map_tb.sv ***
// Self-checking testbench of the conditioner register bank
`timescale 1ns/1ns
module sensor_conditioner_register_map_tb;
    import cond_regs_pkg::*;
    logic clk;
    logic rst;
    logic [4:0] addr;
    logic [15:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [15:0] rdData;
    logic convValid;
    logic [15:0] convRaw;
    logic [15:0] faultComparators;
    logic [15:0] fineOffset, fineGain, refAndLin, coarseAndGain, scaleLimit, tempCtrl, oeCount;
    logic internalTempMode;
    logic [15:0] outs [1:7];
    logic [15:0] seen;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    localparam logic [15:0] RST [0:8] = '{RST_TEMP_RESULT, RST_FINE_OFFSET, RST_FINE_GAIN, RST_REF_LIN,
        RST_COARSE_GAIN, RST_SCALE_LIMIT, RST_TEMP_CTRL, RST_OE_COUNT, RST_ALARM};

    sensor_conditioner_register_map u_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .convValid(convValid), .convRaw(convRaw),
        .faultComparators(faultComparators), .fineOffset(fineOffset), .fineGain(fineGain),
        .refAndLin(refAndLin), .coarseAndGain(coarseAndGain), .scaleLimit(scaleLimit), .tempCtrl(tempCtrl),
        .oeCount(oeCount), .internalTempMode(internalTempMode));
    host_model u_host (.clk(clk), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData));

    // Settings indexed by register number
    always_comb outs = '{fineOffset, fineGain, refAndLin, coarseAndGain, scaleLimit, tempCtrl, oeCount};

    function automatic logic [15:0] val(int i);
        return {4{i[3:0]}} ^ 16'hA5C3;
    endfunction

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic test_reset;
        for (int i = 0; i <= 8; i++)
        begin
            u_host.get(5'(i), seen);
            check(seen, RST[i]);
            if (i inside {[1:7]}) check(outs[i], RST[i]);
        end
        $display("test_reset done");
    endtask

    // Write then read back at once, no gap
    task automatic test_rw;
        logic [15:0] d;
        for (int i = 1; i <= 7; i++)
        begin
            d = val(i);
            u_host.put(5'(i), d);
            u_host.get(5'(i), seen);
            check(seen, d);
            @(posedge clk);
            check(outs[i], d);
            if (i == 6) check({15'h0, internalTempMode}, {15'h0, d[TEMP_MODE_BIT]});
        end
        $display("test_rw done");
    endtask

    // Read-only and unused pointers, including ones that differ only in the top bit
    task automatic test_refuse;
        logic [4:0] bad [6] = '{5'h00, 5'h08, 5'h09, 5'h10, 5'h11, 5'h1f};
        foreach (bad[k])
        begin
            u_host.put(bad[k], 16'hFFFF);
            u_host.get(bad[k], seen);
            check(seen, 16'h0000);
        end
        for (int i = 1; i <= 7; i++)
            check(outs[i], val(i));
        $display("test_refuse done");
    endtask

    // One converter result, then read it back
    task automatic conv(input logic [15:0] raw);
        repeat (2) @(posedge clk);
        convValid <= 1'b1;
        convRaw <= raw;
        @(posedge clk);
        convValid <= 1'b0;
        convRaw <= ~raw;
        u_host.get(ADDR_TEMP_RESULT, seen);
    endtask

    // Upper raw bits are junk in internal mode and must be dropped
    task automatic test_temp;
        logic [31:0] inner [5] = '{32'hBE70_FE70, 32'h1C90_FC90, 32'hE320_0320, 32'h07FF_07FF, 32'h1FFC_FFFC};
        logic [31:0] outer [4] = '{32'h8000_8000, 32'h7FFF_7FFF, 32'h1D71_1D71, 32'hE28F_E28F};
        u_host.put(ADDR_TEMP_CTRL, 16'h0200);
        foreach (inner[k])
        begin
            conv(inner[k][31:16]);
            check(seen, inner[k][15:0]);
        end
        u_host.put(ADDR_TEMP_CTRL, 16'h0000);
        foreach (outer[k])
        begin
            conv(outer[k][31:16]);
            check(seen, outer[k][15:0]);
        end
        $display("test_temp done");
    endtask

    task automatic test_alarm;
        logic [15:0] f [2] = '{16'hA5F0, 16'h0F0F};
        foreach (f[k])
        begin
            faultComparators <= f[k];
            repeat (5) @(posedge clk);
            u_host.get(ADDR_ALARM, seen);
            check(seen, f[k]);
        end
        $display("test_alarm done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            complete_run();
        end
    end

    // Main sequence, with a second reset mid-run
    initial
    begin
        rst = 1'b1;
        convValid = 1'b0;
        convRaw = 16'h0000;
        faultComparators = 16'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_rw();
        test_refuse();
        test_temp();
        test_alarm();
        faultComparators <= 16'h0000;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        complete_run();
    end
endmodule
